// *** verilog/ses_top.sv ***
// Servo enable sequencer: readiness, pole estimation, brakes, saturation.
// How it works
// (R1) Ready needs init done, main power, no alarm and link synchronised.
// (R2) Protection arms after the power-up wait; host settles inputs first.
// (R3) With scheme two, pole completion output rises only after estimation finished correctly.
// (R4) With setup-four bit0 set, servo-active flag reads off until pole done.
// (R5) Estimation runs only with scheme two; other schemes mark it invalid.
// (R6) Scheme zero or estimation error three keeps completion low while present.
// (R7) Servo-on waits while speed is at or above the threshold.
// (R8) Stalled servo-off de-energises the stall brake time after the brake.
// (R9) Running brake delay ends at time elapsed or speed below release speed.
// (R10) A repeated servo-on during deceleration waits until the motor stops.
// (R11) Servo-off dynamic brake and energisation follow servo-off sequence.
// (R12) Alarm during servo-on drives dynamic brake per alarm sequence.
// (R13) Saturation held for the set count raises error; zero disables.
// (R14) All parameter delays count whole control ticks, restarting each time.
`timescale 1ns/100ps
`default_nettype none
`include "ses_regs.svh"
module ses_top #(
   parameter int TICK_CYCLES = `SES_TICK_CYCLES
) (
   input  wire logic        clock_i,
   input  wire logic        srst_i,
   input  wire logic        wb_cyc_i,
   input  wire logic        wb_stb_i,
   input  wire logic        wb_we_i,
   input  wire logic [5:0]  wb_adr_i,
   input  wire logic [3:0]  wb_sel_i,
   input  wire logic [31:0] wb_dat_i,
   output logic [31:0]      wb_dat_o,
   output logic             wb_ack_o,
   input  wire logic        init_done_i,
   input  wire logic        main_power_i,
   input  wire logic        alarm_i,
   input  wire logic        link_sync_i,
   input  wire logic        servo_on_req_i,
   input  wire logic [15:0] speed_i,
   input  wire logic        pole_est_done_i,
   input  wire logic        pole_est_err3_i,
   input  wire logic        thrust_sat_i,
   output logic             servo_ready_o,
   output logic             prot_active_o,
   output logic             pole_est_start_o,
   output logic             pole_done_o,
   output logic             servo_active_o,
   output logic             energise_o,
   output logic             brake_release_o,
   output logic             dyn_brake_o,
   output logic             sat_err_o,
   output logic             irq_o
);
   logic [3:0]  ctrl_r;
   logic [3:0]  pole_cfg_r;
   logic [15:0] wait_r, brk_stall_r, brk_run_r, brk_speed_r;
   logic [15:0] sat_limit_r, speed_stop_r, sat_cnt_r;
   logic [3:0]  irq_stat_r, irq_mask_r, irq_ev;
   logic        tick, prot_done, brk_done, brk_start, stall_r;
   logic        est_started_r, ready_q_r, pole_q_r;
   logic        bus_req, bus_wr;
   logic [3:0]  adr;
   ses_pkg::ses_state_t st_r;

   function automatic logic hit(input logic [3:0] a, input logic [3:0] r);
      return a == r;
   endfunction

   assign adr     = wb_adr_i[5:2];
   assign bus_req = wb_cyc_i && wb_stb_i && !wb_ack_o;
   assign bus_wr  = bus_req && wb_we_i && wb_sel_i[0];

   ses_tick #(.CYCLES(TICK_CYCLES)) u_tick (
      .clock_i (clock_i),
      .srst_i  (srst_i),
      .tick_o  (tick)
   );

   // The power-up timer starts once, at the first cycle after reset.
   logic pu_start_r;
   always_ff @(posedge clock_i) begin
      pu_start_r <= srst_i;
   end

   ses_delay u_powerup ( // [R2] [R14]
      .clock_i (clock_i),
      .srst_i  (srst_i),
      .tick_i  (tick),
      .start_i (pu_start_r),
      .len_i   (wait_r),
      .done_o  (prot_done)
   );

   ses_delay u_brake ( // [R8] [R9] [R14]
      .clock_i (clock_i),
      .srst_i  (srst_i),
      .tick_i  (tick),
      .start_i (brk_start),
      // The stall flag is only registered at this same edge, so the
      // length is picked from the live speed to match it.
      .len_i   (stopped ? brk_stall_r : brk_run_r),
      .done_o  (brk_done)
   );

   always_ff @(posedge clock_i) begin
      if (srst_i) begin
         ctrl_r       <= 4'h0;
         pole_cfg_r   <= {2'h0, `SES_RST_SCHEME};
         wait_r       <= `SES_RST_WAIT;
         brk_stall_r  <= 16'h0000;
         brk_run_r    <= 16'h0000;
         brk_speed_r  <= `SES_RST_BRK_SPEED;
         sat_limit_r  <= 16'h0000;
         speed_stop_r <= `SES_RST_SPEED_STOP;
         irq_mask_r   <= 4'h0;
      end else if (bus_wr) begin
         if (hit(adr, `SES_ADR_CTRL))       ctrl_r <= wb_dat_i[3:0];
         if (hit(adr, `SES_ADR_POLE_CFG))   pole_cfg_r <= wb_dat_i[3:0];
         if (hit(adr, `SES_ADR_WAIT))       wait_r <= wb_dat_i[15:0];
         if (hit(adr, `SES_ADR_BRK_STALL))  brk_stall_r <= wb_dat_i[15:0];
         if (hit(adr, `SES_ADR_BRK_RUN))    brk_run_r <= wb_dat_i[15:0];
         if (hit(adr, `SES_ADR_BRK_SPEED))  brk_speed_r <= wb_dat_i[15:0];
         if (hit(adr, `SES_ADR_SAT_LIMIT))  sat_limit_r <= wb_dat_i[15:0];
         if (hit(adr, `SES_ADR_SPEED_STOP)) speed_stop_r <= wb_dat_i[15:0];
         if (hit(adr, `SES_ADR_IRQ_MASK))   irq_mask_r <= wb_dat_i[3:0];
      end
   end

   // Read data and a one-cycle acknowledge; unmapped reads return zero.
   always_ff @(posedge clock_i) begin
      if (srst_i) begin
         wb_ack_o <= 1'b0;
         wb_dat_o <= 32'h0000_0000;
      end else begin
         wb_ack_o <= bus_req;
         case (adr)
            `SES_ADR_CTRL:       wb_dat_o <= {28'h0, ctrl_r};
            `SES_ADR_STATUS:     wb_dat_o <= {25'h0, sat_err_o, dyn_brake_o,
                                    brake_release_o, servo_active_o,
                                    pole_done_o, prot_active_o,
                                    servo_ready_o};
            `SES_ADR_IRQ_STAT:   wb_dat_o <= {28'h0, irq_stat_r};
            `SES_ADR_IRQ_MASK:   wb_dat_o <= {28'h0, irq_mask_r};
            `SES_ADR_POLE_CFG:   wb_dat_o <= {28'h0, pole_cfg_r};
            `SES_ADR_WAIT:       wb_dat_o <= {16'h0, wait_r};
            `SES_ADR_BRK_STALL:  wb_dat_o <= {16'h0, brk_stall_r};
            `SES_ADR_BRK_RUN:    wb_dat_o <= {16'h0, brk_run_r};
            `SES_ADR_BRK_SPEED:  wb_dat_o <= {16'h0, brk_speed_r};
            `SES_ADR_SAT_LIMIT:  wb_dat_o <= {16'h0, sat_limit_r};
            `SES_ADR_SPEED_STOP: wb_dat_o <= {16'h0, speed_stop_r};
            default:             wb_dat_o <= 32'h0000_0000;
         endcase
      end
   end

   always_ff @(posedge clock_i) begin
      if (srst_i) begin
         servo_ready_o <= 1'b0;
         prot_active_o <= 1'b0;
      end else begin
         servo_ready_o <= init_done_i && main_power_i && !alarm_i
                          && link_sync_i; // [R1]
         prot_active_o <= prot_done; // [R2]
      end
   end

   // Estimation is launched once, on the first cycle that ready is high with scheme two selected.
   always_ff @(posedge clock_i) begin
      if (srst_i) begin
         est_started_r    <= 1'b0;
         pole_est_start_o <= 1'b0;
         pole_done_o      <= 1'b0;
      end else begin
         pole_est_start_o <= 1'b0;
         if (!est_started_r && servo_ready_o && pole_cfg_r[1:0] == 2'h2) begin
            est_started_r    <= 1'b1; // [R5]
            pole_est_start_o <= 1'b1;
         end
         if (pole_cfg_r[1:0] == 2'h0 || pole_est_err3_i) begin
            pole_done_o <= 1'b0; // [R6]
         end else if (pole_cfg_r[1:0] == 2'h2) begin
            if (est_started_r && pole_est_done_i) pole_done_o <= 1'b1; // [R3]
         end else if (pole_cfg_r[`SES_POLE_EXT5] || servo_ready_o) begin
            pole_done_o <= 1'b1; // [R6]
         end
      end
   end

   // Saturation run counter; a zero limit keeps the error off.
   always_ff @(posedge clock_i) begin
      if (srst_i) begin
         sat_cnt_r <= 16'h0000;
         sat_err_o <= 1'b0;
      end else if (sat_limit_r == 16'h0000 || !thrust_sat_i) begin
         sat_cnt_r <= 16'h0000; // [R13]
      end else if (tick) begin
         if (sat_cnt_r + 16'h0001 >= sat_limit_r) sat_err_o <= 1'b1; // [R13]
         else sat_cnt_r <= sat_cnt_r + 16'h0001;
      end
   end

   wire fault   = alarm_i || sat_err_o;
   wire fast    = speed_i >= `SES_SPEED_ON_MMS;
   wire stopped = speed_i < speed_stop_r;
   wire leave   = !servo_on_req_i || fault;
   assign brk_start = st_r == ses_pkg::SES_ON && leave;

   always_ff @(posedge clock_i) begin
      if (srst_i) begin
         st_r    <= ses_pkg::SES_OFF;
         stall_r <= 1'b1;
      end else begin
         case (st_r)
            ses_pkg::SES_OFF: begin
               if (servo_on_req_i && servo_ready_o && !fault && pole_done_o)
                  st_r <= ses_pkg::SES_WAIT_ON;
            end
            ses_pkg::SES_WAIT_ON: begin
               if (!servo_on_req_i || fault) st_r <= ses_pkg::SES_OFF;
               else if (!fast) st_r <= ses_pkg::SES_ON; // [R7]
            end
            ses_pkg::SES_ON: begin
               if (leave) begin
                  stall_r <= stopped;
                  st_r    <= ses_pkg::SES_BRAKE;
               end
            end
            ses_pkg::SES_BRAKE: begin
               if (brk_done || (!stall_r && speed_i < brk_speed_r))
                  st_r <= ses_pkg::SES_DECEL; // [R8] [R9]
            end
            ses_pkg::SES_DECEL: begin
               if (stopped) st_r <= ses_pkg::SES_OFF; // [R10]
            end
            default: st_r <= ses_pkg::SES_OFF;
         endcase
      end
   end

   // Dynamic brake follows the chosen sequence; coasting energisation follows the servo-off one only.
   wire [1:0] seq = alarm_i ? ctrl_r[3:2] : ctrl_r[1:0];
   always_ff @(posedge clock_i) begin
      if (srst_i) begin
         energise_o      <= 1'b0;
         brake_release_o <= 1'b0;
         dyn_brake_o     <= 1'b0;
         servo_active_o  <= 1'b0;
      end else begin
         brake_release_o <= st_r == ses_pkg::SES_ON;
         energise_o <= st_r == ses_pkg::SES_ON || st_r == ses_pkg::SES_BRAKE
                       || (st_r == ses_pkg::SES_DECEL && seq[1] && !alarm_i);
         dyn_brake_o <= (st_r == ses_pkg::SES_BRAKE
                         || st_r == ses_pkg::SES_DECEL)
                        && !seq[0]; // [R11] [R12]
         servo_active_o <= (st_r == ses_pkg::SES_ON)
                           && !(pole_cfg_r[`SES_POLE_EXT4]
                                && !pole_done_o); // [R4]
      end
   end

   always_ff @(posedge clock_i) begin
      ready_q_r <= servo_ready_o;
      pole_q_r  <= pole_done_o;
   end
   assign irq_ev = {pole_est_err3_i, sat_err_o, pole_done_o && !pole_q_r,
                    servo_ready_o && !ready_q_r};

   // Set wins over a write-one clear in the same cycle.
   always_ff @(posedge clock_i) begin
      if (srst_i) irq_stat_r <= 4'h0;
      else if (bus_wr && hit(adr, `SES_ADR_IRQ_STAT))
         irq_stat_r <= (irq_stat_r & ~wb_dat_i[3:0]) | irq_ev;
      else irq_stat_r <= irq_stat_r | irq_ev;
   end
   assign irq_o = |(irq_stat_r & irq_mask_r);

   a_ready_cause: assert property ( // [R1]
      @(posedge clock_i) disable iff (srst_i)
      servo_ready_o |-> $past(init_done_i && main_power_i && link_sync_i
                              && !alarm_i)) else $error("ready w/o cause");
   a_prot_gate: assert property ( // [R2]
      @(posedge clock_i) disable iff (srst_i)
      prot_active_o |-> $past(prot_done)) else $error("early protection");
   a_pole_scheme0: assert property ( // [R6]
      @(posedge clock_i) disable iff (srst_i)
      $past(pole_cfg_r[1:0] == 2'h0) |-> !pole_done_o)
      else $error("pole done on scheme 0");
   a_pole_est: assert property ( // [R3] [R5]
      @(posedge clock_i) disable iff (srst_i)
      $rose(pole_done_o) && $past(pole_cfg_r[1:0] == 2'h2)
      |-> $past(pole_est_done_i)) else $error("pole done early");
   a_active_mask: assert property ( // [R4]
      @(posedge clock_i) disable iff (srst_i)
      $past(pole_cfg_r[`SES_POLE_EXT4] && !pole_done_o) |-> !servo_active_o)
      else $error("active before pole");
   a_speed_on: assert property ( // [R7]
      @(posedge clock_i) disable iff (srst_i)
      st_r == ses_pkg::SES_WAIT_ON && fast ##1 servo_on_req_i
      |-> st_r != ses_pkg::SES_ON) else $error("on while fast");
   a_decel_hold: assert property ( // [R10]
      @(posedge clock_i) disable iff (srst_i)
      st_r == ses_pkg::SES_DECEL && !stopped |=> st_r == ses_pkg::SES_DECEL)
      else $error("left decel moving");
   a_brake_off: assert property ( // [R8] [R9]
      @(posedge clock_i) disable iff (srst_i)
      st_r == ses_pkg::SES_ON && leave |=> ##1 !brake_release_o)
      else $error("brake not engaged");
   a_sat_zero: assert property ( // [R13]
      @(posedge clock_i) disable iff (srst_i)
      sat_limit_r == 16'h0000 && !sat_err_o |=> !sat_err_o)
      else $error("sat error while off");
   a_dbrake_seq: assert property ( // [R11] [R12]
      @(posedge clock_i) disable iff (srst_i)
      dyn_brake_o |-> $past(!seq[0])) else $error("dyn brake sequence");
   c_on: cover property (@(posedge clock_i) st_r == ses_pkg::SES_ON);
   c_decel: cover property (@(posedge clock_i) st_r == ses_pkg::SES_DECEL);
   c_sat: cover property (@(posedge clock_i) $rose(sat_err_o));
   c_irq: cover property (@(posedge clock_i) irq_o);
endmodule
`default_nettype wire

// *** verilog/ses_regs.svh ***
// Offsets, fields, reset values and timing counts of the enable sequencer.
`ifndef SES_REGS_SVH
`define SES_REGS_SVH
`define SES_ADR_CTRL        4'h0
`define SES_ADR_STATUS      4'h1
`define SES_ADR_IRQ_STAT    4'h2
`define SES_ADR_IRQ_MASK    4'h3
`define SES_ADR_POLE_CFG    4'h4
`define SES_ADR_WAIT        4'h5
`define SES_ADR_BRK_STALL   4'h6
`define SES_ADR_BRK_RUN     4'h7
`define SES_ADR_BRK_SPEED   4'h8
`define SES_ADR_SAT_LIMIT   4'h9
`define SES_ADR_SPEED_STOP  4'hA
`define SES_CTRL_SEQ_OFF    0
`define SES_CTRL_SEQ_ALM    2
`define SES_POLE_SCHEME     0
`define SES_POLE_EXT4       2
`define SES_POLE_EXT5       3
`define SES_ST_READY        0
`define SES_ST_PROT         1
`define SES_ST_POLE_DONE    2
`define SES_ST_ACTIVE       3
`define SES_ST_BRAKE        4
`define SES_ST_DBRAKE       5
`define SES_ST_SAT_ERR      6
`define SES_IRQ_READY       0
`define SES_IRQ_POLE_DONE   1
`define SES_IRQ_SAT_ERR     2
`define SES_IRQ_POLE_ERR    3
`define SES_RST_SCHEME      2'h2
`define SES_RST_WAIT        16'h05DC
`define SES_RST_BRK_SPEED   16'h001E
`define SES_RST_SPEED_STOP  16'h0005
`define SES_TICK_NS         1000000
`define SES_CLK_NS          10
`define SES_TICK_CYCLES     (`SES_TICK_NS / `SES_CLK_NS)
`define SES_SPEED_ON_MMS    16'h001E
`endif

// *** verilog/ses_pkg.sv ***
// Types shared by the servo enable sequencer.
package ses_pkg;
   typedef enum logic [4:0] {
      SES_OFF     = 5'b00001,
      SES_WAIT_ON = 5'b00010,
      SES_ON      = 5'b00100,
      SES_BRAKE   = 5'b01000,
      SES_DECEL   = 5'b10000
   } ses_state_t;
endpackage

// *** verilog/ses_tick.sv ***
// Divider making the one-millisecond control tick enable.
`timescale 1ns/100ps
`default_nettype none
`include "ses_regs.svh"
module ses_tick #(
   parameter int CYCLES = `SES_TICK_CYCLES
) (
   input  wire logic clock_i,
   input  wire logic srst_i,
   output logic      tick_o
);
   logic [31:0] cnt_r;

   always_ff @(posedge clock_i) begin
      if (srst_i) begin
         cnt_r  <= 32'h0000_0000;
         tick_o <= 1'b0;
      end else if (cnt_r == 32'(CYCLES - 1)) begin
         cnt_r  <= 32'h0000_0000;
         tick_o <= 1'b1;
      end else begin
         cnt_r  <= cnt_r + 32'h0000_0001;
         tick_o <= 1'b0;
      end
   end
endmodule
`default_nettype wire

// *** verilog/ses_delay.sv ***
// Tick-counted delay timer that restarts on a start pulse.
`timescale 1ns/100ps
`default_nettype none
module ses_delay #(
   parameter int W = 16
) (
   input  wire logic         clock_i,
   input  wire logic         srst_i,
   input  wire logic         tick_i,
   input  wire logic         start_i,
   input  wire logic [W-1:0] len_i,
   output logic              done_o
);
   logic [W-1:0] cnt_r;

   always_ff @(posedge clock_i) begin
      if (srst_i) begin
         cnt_r  <= '0;
         done_o <= 1'b0;
      end else if (start_i) begin
         cnt_r  <= len_i;
         done_o <= (len_i == '0);
      end else if (tick_i && !done_o) begin
         if (cnt_r <= W'(1)) begin
            cnt_r  <= '0;
            done_o <= 1'b1;
         end else begin
            cnt_r <= cnt_r - W'(1);
         end
      end
   end
endmodule
`default_nettype wire

// *** tb/ses_host.sv ***
// Host controller model that issues servo-on after pole completion.
`timescale 1ns/100ps
`default_nettype none
module ses_host #(
   parameter int LINK_DELAY = 8
) (
   input  wire logic clock_i,
   input  wire logic srst_i,
   input  wire logic pole_done_i,
   input  wire logic want_on_i,
   output logic      init_done_o,
   output logic      link_sync_o,
   output logic      servo_on_req_o
);
   int cnt_r;
   // Inputs settle early, long before the protection wait ends.
   always_ff @(posedge clock_i) begin
      if (srst_i) begin
         cnt_r       <= 0;
         init_done_o <= 1'b0;
         link_sync_o <= 1'b0;
      end else begin
         if (cnt_r < LINK_DELAY) cnt_r <= cnt_r + 1;
         init_done_o <= (cnt_r >= 2);
         link_sync_o <= (cnt_r >= LINK_DELAY);
      end
   end
   // A host never commands servo-on before pole completion.
   always_ff @(posedge clock_i) begin
      if (srst_i) servo_on_req_o <= 1'b0;
      else servo_on_req_o <= want_on_i & pole_done_i;
   end
endmodule
`default_nettype wire

// *** tb/tb.sv ***
// Self-checking bench of the servo enable sequencer.
`timescale 1ns/100ps
`default_nettype none
`include "ses_regs.svh"
module tb;
   logic        clock_i = 1'b0;
   logic        srst_i = 1'b1;
   logic        cyc = 1'b0, stb = 1'b0, we = 1'b0;
   logic [5:0]  adr = 6'h00;
   logic [31:0] wdat = 32'h0, rdat, q;
   logic        ack, pwr = 1'b0, alm = 1'b0, want = 1'b0;
   logic        ini, lnk, req, pdone = 1'b0, perr = 1'b0, sat = 1'b0;
   logic [15:0] speed = 16'h0000;
   logic        rdy, prot, pstart, pole, act, ener, brk, dbk, serr, irq;
   int          errors = 0, checked = 0, cyc_cnt = 0, n;
   always #5 clock_i = ~clock_i;
   ses_top #(.TICK_CYCLES(10)) ses_top_i (.clock_i(clock_i),
      .srst_i(srst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
      .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(wdat), .wb_dat_o(rdat),
      .wb_ack_o(ack), .init_done_i(ini), .main_power_i(pwr),
      .alarm_i(alm), .link_sync_i(lnk), .servo_on_req_i(req),
      .speed_i(speed), .pole_est_done_i(pdone), .pole_est_err3_i(perr),
      .thrust_sat_i(sat), .servo_ready_o(rdy), .prot_active_o(prot),
      .pole_est_start_o(pstart), .pole_done_o(pole),
      .servo_active_o(act), .energise_o(ener), .brake_release_o(brk),
      .dyn_brake_o(dbk), .sat_err_o(serr), .irq_o(irq));
   ses_host ses_host_i (.clock_i(clock_i), .srst_i(srst_i),
      .pole_done_i(pole), .want_on_i(want), .init_done_o(ini),
      .link_sync_o(lnk), .servo_on_req_o(req));
   // The estimator finishes five cycles after each start pulse.
   int          est_cnt = 0;
   always @(posedge clock_i) begin
      if (srst_i) begin
         est_cnt <= 0;
         pdone   <= 1'b0;
      end else if (pstart === 1'b1) begin
         est_cnt <= 5;
         pdone   <= 1'b0;
      end else if (est_cnt == 1) begin
         est_cnt <= 0;
         pdone   <= 1'b1;
      end else if (est_cnt > 1) begin
         est_cnt <= est_cnt - 1;
      end
   end
   always @(posedge clock_i) begin
      cyc_cnt <= cyc_cnt + 1;
      if (cyc_cnt == 60000) begin
         errors = errors + 1;
         print_verdict();
      end
   end
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      checked = checked + 1;
      if (seen !== exp) begin
         errors = errors + 1;
         $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task automatic xfer(input logic w, input logic [3:0] idx,
                       input logic [31:0] d);
      cyc  <= 1'b1;
      stb  <= 1'b1;
      we   <= w;
      adr  <= {idx, 2'b00};
      wdat <= d;
      // Only the acknowledge or the bench timeout ends this wait.
      do begin
         @(posedge clock_i);
      end while (ack !== 1'b1);
      q = rdat;
      cyc <= 1'b0;
      stb <= 1'b0;
      we  <= 1'b0;
      @(posedge clock_i);
   endtask
   task automatic rd(input logic [3:0] idx, input logic [31:0] exp);
      xfer(1'b0, idx, 32'h0);
      check(q, exp);
   endtask
   task automatic waitc(input int c);
      repeat (c) @(posedge clock_i);
   endtask
   task automatic do_reset();
      srst_i <= 1'b1;
      waitc(5);
      srst_i <= 1'b0;
      @(posedge clock_i);
   endtask
   task automatic print_verdict();
      $display("comparisons=%0d mismatches=%0d", checked, errors);
      if (errors == 0 && checked > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask
   initial begin
      @(posedge clock_i);
      do_reset();
      rd(`SES_ADR_WAIT, 32'h000005DC);
      rd(`SES_ADR_POLE_CFG, 32'h00000002);
      rd(`SES_ADR_BRK_SPEED, 32'h0000001E);
      rd(`SES_ADR_SAT_LIMIT, 32'h00000000);
      rd(`SES_ADR_SPEED_STOP, 32'h00000005);
      rd(4'hF, 32'h00000000);
      xfer(1'b1, `SES_ADR_WAIT, 32'h14);
      rd(`SES_ADR_WAIT, 32'h00000014);
      xfer(1'b1, `SES_ADR_IRQ_MASK, 32'h1);
      check(prot, 1'b0);
      // The wait is loaded at reset release, so the reset value still runs.
      for (n = 0; n < 16000 && prot !== 1'b1; n++) @(posedge clock_i);
      check(n > 14000, 1'b1);
      check(prot, 1'b1);
      // Ready waits for main power as the last missing condition.
      waitc(20);
      check(rdy, 1'b0);
      check(pole, 1'b0);
      pwr <= 1'b1;
      waitc(4);
      check(rdy, 1'b1);
      check(irq, 1'b1);
      xfer(1'b1, `SES_ADR_IRQ_STAT, 32'h1);
      check(irq, 1'b0);
      for (n = 0; n < 100 && pole !== 1'b1; n++) @(posedge clock_i);
      check(pole, 1'b1);
      // Speed exactly at the threshold still refuses servo-on.
      speed <= 16'd30;
      want <= 1'b1;
      waitc(50);
      check(act, 1'b0);
      speed <= 16'd0;
      waitc(10);
      check({act, ener, brk}, 3'b111);
      // Stalled servo-off keeps energisation for the stall brake time.
      xfer(1'b1, `SES_ADR_BRK_STALL, 32'h3);
      want <= 1'b0;
      for (n = 0; n < 10 && brk !== 1'b0; n++) @(posedge clock_i);
      waitc(15);
      check(ener, 1'b1);
      check(dbk, 1'b1);
      waitc(25);
      check(ener, 1'b0);
      waitc(10);
      want <= 1'b1;
      waitc(10);
      speed <= 16'd100;
      waitc(5);
      // Running servo-off: speed below release speed ends the delay.
      xfer(1'b1, `SES_ADR_BRK_RUN, 32'h32);
      want <= 1'b0;
      waitc(30);
      check(ener, 1'b1);
      speed <= 16'd20;
      waitc(20);
      check(ener, 1'b0);
      // Sequence three: no dynamic brake, energised while decelerating.
      xfer(1'b1, `SES_ADR_CTRL, 32'h3);
      waitc(1);
      check(ener, 1'b1);
      check(dbk, 1'b0);
      want <= 1'b1;
      waitc(100);
      check(act, 1'b0);
      speed <= 16'd0;
      waitc(20);
      check(act, 1'b1);
      // An alarm uses the alarm sequence, which still selects the brake.
      alm <= 1'b1;
      waitc(5);
      check(rdy, 1'b0);
      check(dbk, 1'b1);
      alm <= 1'b0;
      // Saturation is ignored at limit zero and trips at limit four.
      sat <= 1'b1;
      waitc(100);
      check(serr, 1'b0);
      xfer(1'b1, `SES_ADR_SAT_LIMIT, 32'h4);
      waitc(80);
      check(serr, 1'b1);
      rd(`SES_ADR_IRQ_STAT, 32'h00000007);
      sat <= 1'b0;
      want <= 1'b0;
      do_reset();
      xfer(1'b1, `SES_ADR_POLE_CFG, 32'h0);
      waitc(300);
      check(pole, 1'b0);
      check(pstart, 1'b0);
      // Scheme one completes on ready, but estimation error three blocks it.
      perr <= 1'b1;
      xfer(1'b1, `SES_ADR_POLE_CFG, 32'h1);
      waitc(20);
      check(pole, 1'b0);
      rd(`SES_ADR_IRQ_STAT, 32'h00000009);
      perr <= 1'b0;
      waitc(3);
      check(pole, 1'b1);
      print_verdict();
   end
endmodule
`default_nettype wire
